// ===== dadc_pkg.sv
// shared constants, field positions and carrier types for the converter status block
package dadc_pkg;

    // special function addresses
    localparam logic [7:0] ADDR_STATUS    = 8'hD8;
    localparam logic [7:0] ADDR_MODE      = 8'hD1;
    localparam logic [7:0] ADDR_PRES_HIGH = 8'hDA;
    localparam logic [7:0] ADDR_PRES_MID  = 8'hDB;
    localparam logic [7:0] ADDR_ARES_HIGH = 8'hDC;
    localparam logic [7:0] ADDR_ARES_LOW  = 8'hDD;
    localparam logic [7:0] ADDR_POFS_HIGH = 8'hE1;
    localparam logic [7:0] ADDR_POFS_MID  = 8'hE2;
    localparam logic [7:0] ADDR_AOFS_HIGH = 8'hE3;
    localparam logic [7:0] ADDR_AOFS_LOW  = 8'hE4;
    localparam logic [7:0] ADDR_PGN_HIGH  = 8'hE9;
    localparam logic [7:0] ADDR_PGN_MID   = 8'hEA;
    localparam logic [7:0] ADDR_AGN_HIGH  = 8'hEB;
    localparam logic [7:0] ADDR_AGN_LOW   = 8'hEC;

    // bit-addressable window: upper five bits of a bit address pick the byte
    localparam logic [4:0] STATUS_BIT_BASE = 5'h1B;

    // status field positions
    localparam int BIT_PRIM_DONE  = 7;
    localparam int BIT_AUX_DONE   = 6;
    localparam int BIT_CAL_DONE   = 5;
    localparam int BIT_MISS_VREF  = 4;
    localparam int BIT_PRIM_CLAMP = 3;
    localparam int BIT_AUX_CLAMP  = 2;

    // mode register fields
    localparam int BIT_PRIM_EN = 5;
    localparam int BIT_AUX_EN  = 4;
    localparam int MODE_LSB    = 0;

    // reset values
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [7:0]  READ_NONE  = 8'h00;
    localparam logic [15:0] DEF_OFFSET = 16'h8000;
    localparam logic [15:0] DEF_GAIN   = 16'h5555;

    // clamp and forced values
    localparam logic [15:0] RES_ALL_ONES  = 16'hFFFF;
    localparam logic [15:0] RES_ALL_ZEROS = 16'h0000;

    // operating mode codes
    localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
    localparam logic [2:0] MODE_SINGLE     = 3'h2;

    // one cycle of converter activity, from modulator and filter logic on ref_clk
    typedef struct packed {
        logic        convDone; // conversion result ready
        logic        calDone;  // calibration finished
        logic        calGain;  // 1: full-scale (gain) cal, 0: zero-scale (offset) cal
        logic        calFail;  // calibration could not produce a coefficient
        logic [15:0] data;     // result or new coefficient
    } dadc_event_t;

    // what a channel shows back to the top
    typedef struct packed {
        logic        ready;
        logic        clamp;
        logic        calTaken;
        logic        convTaken;
        logic [15:0] result;
        logic [15:0] offset;
        logic [15:0] gain;
    } dadc_chan_t;

endpackage : dadc_pkg

// ===== dadc_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module dadc_sync
    import dadc_pkg::*;
#(
    parameter int WIDTH = 1
)(
    // clock and control
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             clkEn,
    // level in and out
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // first stage is read only by the second
    always_comb
    begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (clkEn)
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;

endmodule : dadc_sync

// ===== dadc_chan.sv
// one converter channel: ready and clamp flags, result and coefficient holding
`timescale 1ns/1ps
module dadc_chan
    import dadc_pkg::*;
#(
    parameter logic [15:0] OFFSET_RST = DEF_OFFSET,
    parameter logic [15:0] GAIN_RST   = DEF_GAIN
)(
    // clock and control
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        clkEn,
    // software side
    input  wire logic        modeWrite,
    input  wire logic        readyClr,
    input  wire logic        clampClr,
    // converter side
    input  wire dadc_event_t evt,
    input  wire logic        forceOnes,
    // state
    output dadc_chan_t       st
);

    logic        ready_q,  ready_d;
    logic        clamp_q,  clamp_d;
    logic        calT_q,   calT_d;
    logic        convT_q,  convT_d;
    logic [15:0] result_q, result_d;
    logic [15:0] offset_q, offset_d;
    logic [15:0] gain_q,   gain_d;

    // next state; a completion is refused while ready is still set
    always_comb
    begin
        logic        take;
        logic [15:0] value;
        take     = (evt.convDone | evt.calDone) & ~ready_q;
        value    = forceOnes ? RES_ALL_ONES : evt.data;
        ready_d  = ready_q;
        clamp_d  = clamp_q;
        result_d = result_q;
        offset_d = offset_q;
        gain_d   = gain_q;
        calT_d   = take & evt.calDone;
        convT_d  = take & evt.convDone;
        // clears first so that a same-cycle set wins
        if (modeWrite | readyClr)
            ready_d = 1'b0;
        if (modeWrite | clampClr)
            clamp_d = 1'b0;
        if (take)
        begin
            ready_d = 1'b1;
            if (evt.convDone)
            begin
                result_d = value;
                if (value == RES_ALL_ONES || value == RES_ALL_ZEROS)
                    clamp_d = 1'b1;
            end
            else if (evt.calFail)
                clamp_d = 1'b1;
            else if (evt.calGain)
                gain_d = evt.data;
            else
                offset_d = evt.data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ready_q  <= 1'b0;
            clamp_q  <= 1'b0;
            calT_q   <= 1'b0;
            convT_q  <= 1'b0;
            result_q <= RES_ALL_ZEROS;
            offset_q <= OFFSET_RST;
            gain_q   <= GAIN_RST;
        end
        else if (clkEn)
        begin
            ready_q  <= ready_d;
            clamp_q  <= clamp_d;
            calT_q   <= calT_d;
            convT_q  <= convT_d;
            result_q <= result_d;
            offset_q <= offset_d;
            gain_q   <= gain_d;
        end
    end

    assign st = '{ready: ready_q, clamp: clamp_q, calTaken: calT_q, convTaken: convT_q,
                  result: result_q, offset: offset_q, gain: gain_q};

endmodule : dadc_chan

// ===== dadc_status.sv
// status and result special function registers for the primary and auxiliary converters
`timescale 1ns/1ps
module dadc_status
    import dadc_pkg::*;
#(
    parameter logic [15:0] PRIM_OFFSET_RST = DEF_OFFSET,
    parameter logic [15:0] PRIM_GAIN_RST   = DEF_GAIN,
    parameter logic [15:0] AUX_OFFSET_RST  = DEF_OFFSET,
    parameter logic [15:0] AUX_GAIN_RST    = DEF_GAIN
)(
    // clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        clkEn,
    // byte access from the core
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrEn,
    input  wire logic [7:0]  sfrWrData,
    input  wire logic        sfrRdEn,
    output logic      [7:0]  sfrRdData,
    // single-bit access from the core
    input  wire logic        bitWrEn,
    input  wire logic [7:0]  bitAddr,
    input  wire logic        bitWrVal,
    // converter activity
    input  wire dadc_event_t primEvt,
    input  wire dadc_event_t auxEvt,
    input  wire logic        primExtRef,
    input  wire logic        auxExtRef,
    // reference detect pin
    input  wire logic        refMissingPin,
    // converter control
    output logic             convReset,
    output logic             primEnable,
    output logic             auxEnable,
    output logic      [2:0]  modeBits,
    output logic      [7:0]  statusOut
);

    dadc_chan_t primSt;
    dadc_chan_t auxSt;
    logic       refMissingSync;

    logic       missing_q,  missing_d;
    logic       cal_q,      cal_d;
    logic [7:0] mode_q,     mode_d;
    logic       reset_q,    reset_d;
    logic       primSeen_q, primSeen_d;
    logic       auxSeen_q,  auxSeen_d;
    logic [7:0] rdData_q,   rdData_d;

    logic       statusByteWr;
    logic       statusBitWr;
    logic [2:0] bitSel;
    logic       modeWrite;
    logic       primRdyClr, auxRdyClr, calClr;
    logic       primErrClr, auxErrClr;
    logic [7:0] statusNow;

    // pin level crosses in before anything looks at it
    dadc_sync #(
        .WIDTH   (1)
    ) u_refSync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clkEn   (clkEn),
        .asyncIn (refMissingPin),
        .syncOut (refMissingSync)
    );

    // software write decode; a write of 0 clears a flag, 1 leaves it
    always_comb
    begin
        statusByteWr = sfrWrEn & (sfrAddr == ADDR_STATUS);
        statusBitWr  = bitWrEn & (bitAddr[7:3] == STATUS_BIT_BASE);
        bitSel       = bitAddr[2:0];
        modeWrite    = sfrWrEn & (sfrAddr == ADDR_MODE); // value unchanged still counts
        primRdyClr   = (statusByteWr & ~sfrWrData[BIT_PRIM_DONE])
                     | (statusBitWr & ~bitWrVal & (bitSel == 3'(BIT_PRIM_DONE)));
        auxRdyClr    = (statusByteWr & ~sfrWrData[BIT_AUX_DONE])
                     | (statusBitWr & ~bitWrVal & (bitSel == 3'(BIT_AUX_DONE)));
        calClr       = (statusByteWr & ~sfrWrData[BIT_CAL_DONE])
                     | (statusBitWr & ~bitWrVal & (bitSel == 3'(BIT_CAL_DONE)));
        primErrClr   = (statusByteWr & ~sfrWrData[BIT_PRIM_CLAMP])
                     | (statusBitWr & ~bitWrVal & (bitSel == 3'(BIT_PRIM_CLAMP)));
        auxErrClr    = (statusByteWr & ~sfrWrData[BIT_AUX_CLAMP])
                     | (statusBitWr & ~bitWrVal & (bitSel == 3'(BIT_AUX_CLAMP)));
    end

    // primary channel
    dadc_chan #(
        .OFFSET_RST (PRIM_OFFSET_RST),
        .GAIN_RST   (PRIM_GAIN_RST)
    ) u_prim (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .clkEn      (clkEn),
        .modeWrite  (modeWrite),
        .readyClr   (primRdyClr),
        .clampClr   (primErrClr),
        .evt        (primEvt),
        .forceOnes  (missing_q & primExtRef),
        .st         (primSt)
    );

    // auxiliary channel, identical behaviour
    dadc_chan #(
        .OFFSET_RST (AUX_OFFSET_RST),
        .GAIN_RST   (AUX_GAIN_RST)
    ) u_aux (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .clkEn      (clkEn),
        .modeWrite  (modeWrite),
        .readyClr   (auxRdyClr),
        .clampClr   (auxErrClr),
        .evt        (auxEvt),
        .forceOnes  (missing_q & auxExtRef),
        .st         (auxSt)
    );

    // live status byte; low two bits are hardwired zero
    always_comb
    begin
        statusNow                 = STATUS_RST;
        statusNow[BIT_PRIM_DONE]  = primSt.ready;
        statusNow[BIT_AUX_DONE]   = auxSt.ready;
        statusNow[BIT_CAL_DONE]   = cal_q;
        statusNow[BIT_MISS_VREF]  = missing_q;
        statusNow[BIT_PRIM_CLAMP] = primSt.clamp;
        statusNow[BIT_AUX_CLAMP]  = auxSt.clamp;
    end

    // flags, mode register and the converter reset pulse
    always_comb
    begin
        logic primActive;
        logic auxActive;
        logic allDone;
        primActive = mode_q[BIT_PRIM_EN] & (mode_q[MODE_LSB +: 3] != MODE_POWER_DOWN);
        auxActive  = mode_q[BIT_AUX_EN] & (mode_q[MODE_LSB +: 3] != MODE_POWER_DOWN);
        // a level, not sticky: follows the pin only while a converter runs
        missing_d  = refMissingSync & (primActive | auxActive);
        cal_d      = cal_q;
        if (modeWrite | calClr)
            cal_d = 1'b0;
        if (primSt.calTaken | auxSt.calTaken)
            cal_d = 1'b1;
        reset_d    = modeWrite;
        primSeen_d = modeWrite ? 1'b0 : (primSeen_q | primSt.convTaken);
        auxSeen_d  = modeWrite ? 1'b0 : (auxSeen_q | auxSt.convTaken);
        allDone    = (primSeen_d | ~mode_q[BIT_PRIM_EN]) & (auxSeen_d | ~mode_q[BIT_AUX_EN])
                   & (mode_q[BIT_PRIM_EN] | mode_q[BIT_AUX_EN]);
        mode_d     = mode_q;
        if (modeWrite)
            mode_d = sfrWrData;
        else if (mode_q[MODE_LSB +: 3] == MODE_SINGLE && allDone)
            mode_d[MODE_LSB +: 3] = MODE_POWER_DOWN;
    end

    // registered read answer; unmapped addresses read zero
    always_comb
    begin
        rdData_d = rdData_q;
        if (sfrRdEn)
        begin
            unique case (sfrAddr)
                ADDR_STATUS:    rdData_d = statusNow;
                ADDR_MODE:      rdData_d = mode_q;
                ADDR_PRES_HIGH: rdData_d = primSt.result[15:8];
                ADDR_PRES_MID:  rdData_d = primSt.result[7:0];
                ADDR_ARES_HIGH: rdData_d = auxSt.result[15:8];
                ADDR_ARES_LOW:  rdData_d = auxSt.result[7:0];
                ADDR_POFS_HIGH: rdData_d = primSt.offset[15:8];
                ADDR_POFS_MID:  rdData_d = primSt.offset[7:0];
                ADDR_AOFS_HIGH: rdData_d = auxSt.offset[15:8];
                ADDR_AOFS_LOW:  rdData_d = auxSt.offset[7:0];
                ADDR_PGN_HIGH:  rdData_d = primSt.gain[15:8];
                ADDR_PGN_MID:   rdData_d = primSt.gain[7:0];
                ADDR_AGN_HIGH:  rdData_d = auxSt.gain[15:8];
                ADDR_AGN_LOW:   rdData_d = auxSt.gain[7:0];
                default:        rdData_d = READ_NONE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            missing_q  <= 1'b0;
            cal_q      <= 1'b0;
            mode_q     <= MODE_RST;
            reset_q    <= 1'b0;
            primSeen_q <= 1'b0;
            auxSeen_q  <= 1'b0;
            rdData_q   <= READ_NONE;
        end
        else if (clkEn)
        begin
            missing_q  <= missing_d;
            cal_q      <= cal_d;
            mode_q     <= mode_d;
            reset_q    <= reset_d;
            primSeen_q <= primSeen_d;
            auxSeen_q  <= auxSeen_d;
            rdData_q   <= rdData_d;
        end
    end

    // outputs straight from flops
    assign sfrRdData  = rdData_q;
    assign convReset  = reset_q;
    assign primEnable = mode_q[BIT_PRIM_EN];
    assign auxEnable  = mode_q[BIT_AUX_EN];
    assign modeBits   = mode_q[MODE_LSB +: 3];
    assign statusOut  = statusNow;

endmodule : dadc_status

// ===== dadc_status_sva.sv
// concurrent checks on the ports of the converter status block
`timescale 1ns/1ps
module dadc_status_sva
    import dadc_pkg::*;
(
    // clock and control
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        clkEn,
    // core access
    input wire logic [7:0]  sfrAddr,
    input wire logic        sfrWrEn,
    input wire logic        bitWrEn,
    input wire logic [7:0]  bitAddr,
    input wire logic        bitWrVal,
    // converter side
    input wire dadc_event_t primEvt,
    input wire dadc_event_t auxEvt,
    input wire logic        refMissingPin,
    // observed outputs
    input wire logic        convReset,
    input wire logic        primEnable,
    input wire logic [2:0]  modeBits,
    input wire logic [7:0]  statusOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // helper terms; software writes excluded where set versus clear order is a choice
    logic anyWr;
    logic modeWr;
    logic evtAny;
    logic primHit;
    logic auxHit;
    assign anyWr   = sfrWrEn || bitWrEn;
    assign modeWr  = clkEn && sfrWrEn && (sfrAddr == ADDR_MODE);
    assign evtAny  = primEvt.convDone || primEvt.calDone || auxEvt.convDone || auxEvt.calDone;
    assign primHit = clkEn && !anyWr && !statusOut[BIT_PRIM_DONE] && (primEvt.convDone || primEvt.calDone);
    assign auxHit  = clkEn && !anyWr && !statusOut[BIT_AUX_DONE] && (auxEvt.convDone || auxEvt.calDone);

    // calibration taken, then a quiet cycle before the flag lands
    sequence s_cal_taken;
        primHit && primEvt.calDone && !primEvt.convDone;
    endsequence
    sequence s_quiet;
        !modeWr;
    endsequence
    sequence s_clean_mode_wr;
        !evtAny ##1 (modeWr && !evtAny);
    endsequence

    a_prim_ready: assert property (primHit |=> statusOut[BIT_PRIM_DONE])
        else $error("primary ready flag not set");
    a_aux_ready: assert property (auxHit |=> statusOut[BIT_AUX_DONE])
        else $error("auxiliary ready flag not set");
    a_cal_flag: assert property (s_cal_taken ##1 s_quiet |=> statusOut[BIT_CAL_DONE])
        else $error("calibration flag not set");
    a_mode_pulse: assert property (modeWr |=> convReset)
        else $error("mode write gave no converter reset");
    a_mode_clear: assert property (s_clean_mode_wr |=> (statusOut & 8'hEC) == 8'h00)
        else $error("mode write left flags set");
    a_prim_clamp: assert property (primHit && primEvt.convDone &&
        (primEvt.data == RES_ALL_ONES || primEvt.data == RES_ALL_ZEROS) |=> statusOut[BIT_PRIM_CLAMP])
        else $error("clamped primary result not flagged");
    a_aux_clamp: assert property (auxHit && auxEvt.convDone &&
        (auxEvt.data == RES_ALL_ONES || auxEvt.data == RES_ALL_ZEROS) |=> statusOut[BIT_AUX_CLAMP])
        else $error("clamped auxiliary result not flagged");
    a_cal_fail: assert property (s_cal_taken and primEvt.calFail |=> statusOut[BIT_PRIM_CLAMP])
        else $error("failed calibration not flagged");
    a_rsvd_zero: assert property (statusOut[1:0] == 2'h0)
        else $error("reserved status bits not zero");
    a_vref_on: assert property ((clkEn && refMissingPin && primEnable &&
        modeBits != MODE_POWER_DOWN)[*5] |-> statusOut[BIT_MISS_VREF])
        else $error("missing reference not flagged");
    a_vref_off: assert property ((clkEn && !refMissingPin)[*5] |-> !statusOut[BIT_MISS_VREF])
        else $error("missing reference flag with valid reference");
    a_bit_clear: assert property (clkEn && bitWrEn && bitAddr == {STATUS_BIT_BASE, 3'h7} && !bitWrVal &&
        !primEvt.convDone && !primEvt.calDone |=> !statusOut[BIT_PRIM_DONE])
        else $error("single-bit clear of primary ready failed");
endmodule : dadc_status_sva

bind dadc_status dadc_status_sva u_sva (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .bitWrEn(bitWrEn), .bitAddr(bitAddr), .bitWrVal(bitWrVal), .primEvt(primEvt),
    .auxEvt(auxEvt), .refMissingPin(refMissingPin), .convReset(convReset), .primEnable(primEnable),
    .modeBits(modeBits), .statusOut(statusOut));

// ===== dadc_core_model.sv
// behavioural core model issuing byte and bit accesses to the status block
`timescale 1ns/1ps
module dadc_core_model
    import dadc_pkg::*;
(
    // clock
    input  wire logic       ref_clk,
    // byte access
    output logic      [7:0] sfrAddr,
    output logic            sfrWrEn,
    output logic      [7:0] sfrWrData,
    output logic            sfrRdEn,
    input  wire logic [7:0] sfrRdData,
    // bit access
    output logic            bitWrEn,
    output logic      [7:0] bitAddr,
    output logic            bitWrVal
);
    // idle bus at time zero
    initial
    begin
        sfrAddr   = 8'h00;
        sfrWrEn   = 1'b0;
        sfrWrData = 8'h00;
        sfrRdEn   = 1'b0;
        bitWrEn   = 1'b0;
        bitAddr   = 8'h00;
        bitWrVal  = 1'b0;
    end

    // each access opens a cycle late so back-to-back calls never retoggle a strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfrAddr   = a;
        sfrWrData = d;
        sfrWrEn   = 1'b1;
        @(posedge ref_clk);
        #1;
        sfrWrEn   = 1'b0;
        sfrWrData = ~d; // released data shows the inverse, never a stale copy
    endtask : wr

    // answer is registered, so it is taken just after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(posedge ref_clk);
        #1;
        sfrRdEn = 1'b0;
        d       = sfrRdData;
    endtask : rd

    // single-bit write into the bit-addressable window
    task automatic bwr(input logic [7:0] a, input logic v);
        @(posedge ref_clk);
        #1;
        bitAddr  = a;
        bitWrVal = v;
        bitWrEn  = 1'b1;
        @(posedge ref_clk);
        #1;
        bitWrEn  = 1'b0;
        bitWrVal = ~v;
    endtask : bwr
endmodule : dadc_core_model

// ===== dual_adc_status_sfr_interface_tb.sv
// self-checking bench for the converter status block
`timescale 1ns/1ps
module dual_adc_status_sfr_interface_tb;
    import dadc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  sfrAddr, sfrWrData, sfrRdData, bitAddr, statusOut;
    logic        sfrWrEn, sfrRdEn, bitWrEn, bitWrVal;
    logic        primExtRef = 1'b0;
    logic        auxExtRef = 1'b0;
    logic        clkEn = 1'b1;
    logic        refMissingPin = 1'b0;
    logic        convReset, primEnable, auxEnable;
    logic [2:0]  modeBits;
    dadc_event_t primEvt = '0;
    dadc_event_t auxEvt = '0;
    logic [15:0] v;
    logic [7:0]  b;
    int          nFail = 0;
    int          checked = 0;

    always #20 ref_clk = ~ref_clk;

    dadc_core_model core (.ref_clk(ref_clk), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
        .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .bitWrEn(bitWrEn), .bitAddr(bitAddr), .bitWrVal(bitWrVal));

    // clock enable driven so that a frozen write can be tried
    dadc_status dut (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .bitWrEn(bitWrEn), .bitAddr(bitAddr),
        .bitWrVal(bitWrVal), .primEvt(primEvt), .auxEvt(auxEvt), .primExtRef(primExtRef), .auxExtRef(auxExtRef),
        .refMissingPin(refMissingPin), .convReset(convReset), .primEnable(primEnable), .auxEnable(auxEnable),
        .modeBits(modeBits), .statusOut(statusOut));

    task automatic test_done;
        if (nFail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    function automatic dadc_event_t ev(input logic cv, cl, gn, fl, input logic [15:0] d);
        return '{convDone: cv, calDone: cl, calGain: gn, calFail: fl, data: d};
    endfunction : ev

    // one-cycle converter pulse; returns just after the edge that takes it
    task automatic fire(input logic aux, input dadc_event_t e);
        cyc(1);
        if (aux)
            auxEvt = e;
        else
            primEvt = e;
        cyc(1);
        primEvt = '0;
        auxEvt  = '0;
    endtask : fire

    task automatic rd16(input logic [7:0] hi, input logic [7:0] lo, output logic [15:0] r);
        core.rd(hi, r[15:8]);
        core.rd(lo, r[7:0]);
    endtask : rd16

    task automatic t_reset;
        chk("status", STATUS_RST, statusOut);
        chk("mode", 16'h0000, modeBits);
        rd16(ADDR_POFS_HIGH, ADDR_POFS_MID, v);
        chk("prim offset", DEF_OFFSET, v);
        rd16(ADDR_AGN_HIGH, ADDR_AGN_LOW, v);
        chk("aux gain", DEF_GAIN, v);
        core.rd(8'h00, b);
        chk("unmapped", READ_NONE, b);
    endtask : t_reset

    task automatic t_results;
        core.wr(ADDR_MODE, 8'h33);
        chk("conv reset", 16'h0001, convReset);
        chk("aux enable", 16'h0001, auxEnable);
        fire(0, ev(1, 0, 0, 0, 16'h1234));
        chk("status", 16'h0080, statusOut);
        fire(0, ev(1, 0, 0, 0, 16'h4321));
        rd16(ADDR_PRES_HIGH, ADDR_PRES_MID, v);
        chk("prim result", 16'h1234, v);
        core.wr(ADDR_STATUS, 8'h7F);
        chk("status", 16'h0000, statusOut);
        fire(0, ev(1, 0, 0, 0, 16'h4321));
        rd16(ADDR_PRES_HIGH, ADDR_PRES_MID, v);
        chk("prim result", 16'h4321, v);
        fire(1, ev(1, 0, 0, 0, 16'h00AB));
        fire(1, ev(1, 0, 0, 0, 16'h1111));
        chk("status", 16'h00C0, statusOut);
        rd16(ADDR_ARES_HIGH, ADDR_ARES_LOW, v);
        chk("aux result", 16'h00AB, v);
        core.bwr({STATUS_BIT_BASE, 3'h6}, 1'b0);
        fire(1, ev(1, 0, 0, 0, RES_ALL_ZEROS));
        chk("status", 16'h00C4, statusOut);
        core.bwr({STATUS_BIT_BASE, 3'h7}, 1'b0);
        fire(0, ev(1, 0, 0, 0, RES_ALL_ONES));
        chk("status", 16'h00CC, statusOut);
    endtask : t_results

    task automatic t_calib;
        core.wr(ADDR_MODE, 8'h33);
        chk("status", 16'h0000, statusOut);
        cyc(1);
        chk("conv reset", 16'h0000, convReset);
        fire(0, ev(0, 1, 0, 0, 16'h7000));
        chk("status", 16'h0080, statusOut);
        cyc(1);
        chk("status", 16'h00A0, statusOut);
        rd16(ADDR_POFS_HIGH, ADDR_POFS_MID, v);
        chk("prim offset", 16'h7000, v);
        core.wr(ADDR_STATUS, 8'h7F);
        fire(0, ev(0, 1, 1, 0, 16'h6000));
        rd16(ADDR_PGN_HIGH, ADDR_PGN_MID, v);
        chk("prim gain", 16'h6000, v);
        core.wr(ADDR_STATUS, 8'h7F);
        fire(0, ev(0, 1, 0, 1, 16'h1111));
        chk("status", 16'h00A8, statusOut);
        rd16(ADDR_POFS_HIGH, ADDR_POFS_MID, v);
        chk("prim offset", 16'h7000, v);
        fire(1, ev(0, 1, 0, 0, 16'h0F0F));
        rd16(ADDR_AOFS_HIGH, ADDR_AOFS_LOW, v);
        chk("aux offset", 16'h0F0F, v);
        core.wr(ADDR_MODE, 8'h33);
        core.wr(ADDR_STATUS, 8'hFF);
        core.bwr({STATUS_BIT_BASE, 3'h1}, 1'b1);
        chk("status", 16'h0000, statusOut);
        fire(0, ev(1, 0, 0, 0, 16'h1234));
        core.rd(ADDR_STATUS, b);
        chk("status read", 16'h0080, b);
    endtask : t_calib

    // both channels on the external reference while it is missing
    task automatic t_vref;
        primExtRef = 1'b1;
        auxExtRef  = 1'b1;
        core.wr(ADDR_STATUS, 8'h7F);
        refMissingPin = 1'b1;
        cyc(3);
        chk("status", 16'h0010, statusOut);
        fire(0, ev(1, 0, 0, 0, 16'h1234));
        rd16(ADDR_PRES_HIGH, ADDR_PRES_MID, v);
        chk("forced result", RES_ALL_ONES, v);
        fire(1, ev(1, 0, 0, 0, 16'h00AB));
        rd16(ADDR_ARES_HIGH, ADDR_ARES_LOW, v);
        chk("forced aux result", RES_ALL_ONES, v);
        refMissingPin = 1'b0;
        cyc(3);
        chk("status", 16'h00CC, statusOut);
        core.wr(ADDR_STATUS, 8'hF3);
        chk("status", 16'h00C0, statusOut);
        core.wr(ADDR_MODE, 8'h00);
        refMissingPin = 1'b1;
        cyc(3);
        chk("status", 16'h0000, statusOut);
        refMissingPin = 1'b0;
        primExtRef = 1'b0;
        auxExtRef  = 1'b0;
    endtask : t_vref

    // single conversion, then a frozen mode write and a reset in mid-run
    task automatic t_single;
        core.wr(ADDR_MODE, 8'h22);
        chk("prim enable", 16'h0001, primEnable);
        chk("aux enable", 16'h0000, auxEnable);
        chk("mode", MODE_SINGLE, modeBits);
        fire(0, ev(1, 0, 0, 0, 16'h5A5A));
        cyc(1);
        chk("mode", MODE_POWER_DOWN, modeBits);
        clkEn = 1'b0;
        core.wr(ADDR_MODE, 8'h33);
        chk("frozen reset", 16'h0000, convReset);
        chk("frozen mode", MODE_POWER_DOWN, modeBits);
        clkEn = 1'b1;
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        chk("status", STATUS_RST, statusOut);
        rd16(ADDR_POFS_HIGH, ADDR_POFS_MID, v);
        chk("prim offset", DEF_OFFSET, v);
    endtask : t_single

    // reset, then scenarios in sequence
    initial
    begin
        repeat (4) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_results();
        t_calib();
        t_vref();
        t_single();
        test_done();
    end

    // watchdog sized well beyond the roughly 130 cycles the scenarios need
    initial
    begin
        #100000;
        nFail++;
        test_done();
    end
endmodule : dual_adc_status_sfr_interface_tb
